// >>> logic/tlim_pkg.sv
// shared constants, register map and types of the ternary link integrity monitor
// assumes a 100 MHz aclk; offsets are byte addresses on a 32-bit AXI4-Lite slave
package tlim_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_NS = 10;
  localparam int LINK_MAX_US = 6000;
  localparam int LINK_MIN_US = 300;
  localparam int LINK_MAX_CYC = LINK_MAX_US * 1000 / CLK_NS;
  localparam int LINK_MIN_CYC = (LINK_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;

  // ==========================================================================
  // pulse thresholds
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] CNT_FIRST = 7'h1F;
  localparam logic [CNT_W-1:0] CNT_MORE = 7'h60;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;

  // ==========================================================================
  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0C;
  localparam int CTRL_LINK_EN_BIT = 0;
  localparam int CTRL_PCS_RST_BIT = 1;
  localparam int ST_LINK_BIT = 0;
  localparam int ST_STATE_LSB = 1;
  localparam int ST_CARRIER_BIT = 4;
  localparam int ST_CNT_LSB = 8;
  localparam int IRQ_W = 3;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ST_FAIL,
    ST_MORE,
    ST_CARRIER_END,
    ST_WAIT_CTRL,
    ST_PASS
  } tlim_state_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } tlim_lvl_t;

  typedef logic [1:0] tlim_sym_t;
  localparam tlim_sym_t SYM_PLUS = 2'h1;
  localparam tlim_sym_t SYM_ZERO = 2'h0;
  localparam tlim_sym_t SYM_MINUS = 2'h3;

  typedef struct packed {
    tlim_sym_t main;
    tlim_sym_t pair_a;
    tlim_sym_t pair_b;
  } tlim_sym3_t;

  typedef struct packed {
    logic link_up;
    logic link_down;
    logic too_close;
  } tlim_irq_t;

  function automatic tlim_lvl_t tlim_encode(input tlim_sym_t s);
    tlim_lvl_t l;
    l.pos = (s == SYM_PLUS);
    l.neg = (s == SYM_MINUS);
    return l;
  endfunction : tlim_encode

  function automatic tlim_sym_t tlim_decode(input tlim_lvl_t l);
    tlim_sym_t s;
    s = SYM_ZERO;
    if (l.pos && !l.neg)
      s = SYM_PLUS;
    else if (l.neg && !l.pos)
      s = SYM_MINUS;
    return s;
  endfunction : tlim_decode

endpackage : tlim_pkg

// >>> logic/tlim_timer.sv
// re-triggerable down-counting window timer
// assumes restart is a single-cycle strobe in the aclk domain
module tlim_timer #(
  parameter int DURATION = 16,
  parameter bit START_DONE = 1'b0
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic restart, // reload full duration
  output logic done, // window has elapsed
  output logic expire // one-cycle strobe at expiry
);

  localparam int W = $clog2(DURATION + 1);
  localparam logic [W-1:0] FULL = W'(DURATION);
  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);

  logic [W-1:0] cnt;
  wire last = (cnt == ONE);

  // ==========================================================================
  // counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= START_DONE ? ZERO : FULL;
      done <= START_DONE;
      expire <= 1'b0;
    end
    else if (ce)
    begin
      expire <= 1'b0;
      if (restart)
      begin
        cnt <= FULL; // R03
        done <= 1'b0; // R03
      end
      else if (last)
      begin
        cnt <= ZERO;
        done <= 1'b1;
        expire <= 1'b1;
      end
      else if (cnt != ZERO)
        cnt <= cnt - ONE;
    end
  end

  chk_restart_clears: assert property (@(posedge aclk) disable iff (!aresetn) // R03
    ce && restart |=> !done && !expire)
    else $error("timer done after restart");

endmodule : tlim_timer

// >>> logic/tlim_monitor.sv
// ternary link integrity monitor: pulse counting, link state, data gating
// assumes link_pulse and carrier arrive synchronous to aclk; AXI4-Lite slave
//
// How it works
// R01 - pulses are declared absent when the window timer, set between 5 and 7 ms, expires
// R02 - pulses closer than a minimum spacing between 0.15 and 0.45 ms are too close
// R03 - every pulse and every carrier rise restarts the window timer and clears expiry
// R04 - outside link pass, a too-close pulse clears the pulse counter
// R05 - window timer expiry clears the pulse counter in every state
// R06 - in link pass, too-close pulses are neither counted nor clear the counter
// R07 - receive disabled: only idle goes upward and carrier status reads off
// R08 - carrier detection always runs; it passes upward only while receive enabled
// R09 - transmit disabled: requests become idle, idle link signal keeps going out
// R10 - sublayer reset has only on and off and resets the coding sublayer
// R11 - sourceless transitions are checked every cycle and override all others
// R12 - received symbols are re-timed on the local clock before use
// R13 - transmit symbols map +1, 0, -1 to positive, zero and negative levels
// R14 - received levels decode with the same mapping as transmit
// R15 - idle link signal goes only on the transmit pair, expected on receive pair
// R16 - link pass needs 31 pulses, then 96 more or carrier, carrier end, control
// R17 - outside link pass both receive and transmit enables stay off
// R18 - link ready only in link pass; window expiry returns to failed state
// R19 - the pulse counter saturates at its top threshold instead of wrapping
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
module tlim_monitor #(
  parameter int LINK_MAX_CYCLES = tlim_pkg::LINK_MAX_CYC,
  parameter int LINK_MIN_CYCLES = tlim_pkg::LINK_MIN_CYC
) (
  input wire logic aclk, // clock, 100 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic link_pulse, // one-cycle strobe per link test pulse on receive_pair
  input wire logic pma_carrier, // internal carrier detect level
  input wire tlim_pkg::tlim_lvl_t receive_pair, // receive pair levels
  input wire tlim_pkg::tlim_lvl_t bidir_pair_a_in, // bidir pair a levels seen
  input wire tlim_pkg::tlim_lvl_t bidir_pair_b_in, // bidir pair b levels seen
  input wire logic tx_valid, // upper layer offers data symbols
  input wire tlim_pkg::tlim_sym3_t tx_sym, // symbols to send
  output tlim_pkg::tlim_lvl_t transmit_pair, // transmit pair levels
  output tlim_pkg::tlim_lvl_t bidir_pair_a_out, // bidir pair a drive levels
  output logic bidir_pair_a_oe, // bidir pair a driven
  output tlim_pkg::tlim_lvl_t bidir_pair_b_out, // bidir pair b drive levels
  output logic bidir_pair_b_oe, // bidir pair b driven
  output logic idle_link_signal, // idle link signal emitted on transmit pair
  output logic rx_valid, // rx_sym carries data
  output tlim_pkg::tlim_sym3_t rx_sym, // re-timed received symbols
  output logic carrier_status, // carrier seen by the upper layer
  output logic rcv_en, // receive enable
  output logic xmit_en, // transmit enable
  output logic link_status, // link ready
  output logic pcs_reset, // sublayer reset, active high
  output logic irq, // level interrupt
  input wire logic [tlim_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [tlim_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  tlim_pkg::tlim_state_t state;
  tlim_pkg::tlim_state_t next_state;
  logic [tlim_pkg::CNT_W-1:0] pulse_cnt;
  logic [tlim_pkg::CNT_W-1:0] next_cnt;
  logic carrier_q;
  logic carrier_seen;
  logic [1:0] ctrl;
  logic [tlim_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  tlim_pkg::tlim_irq_t irq_stat;
  tlim_pkg::tlim_irq_t irq_mask;
  tlim_pkg::tlim_lvl_t rx_main_q;
  tlim_pkg::tlim_lvl_t rx_a_q;
  tlim_pkg::tlim_lvl_t rx_b_q;
  logic max_done;
  logic max_expire;
  logic min_done;

  // ==========================================================================
  // timers
  wire carrier_rise = pma_carrier && !carrier_q;
  wire max_restart = link_pulse || carrier_rise;
  wire too_close = link_pulse && !min_done; // R02

  tlim_timer #(
    .DURATION(LINK_MAX_CYCLES),
    .START_DONE(1'b0)
  ) u_max_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .restart(max_restart), // R03
    .done(max_done),
    .expire(max_expire) // R01
  );

  tlim_timer #(
    .DURATION(LINK_MIN_CYCLES),
    .START_DONE(1'b1)
  ) u_min_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .restart(link_pulse),
    .done(min_done),
    .expire()
  );

  // ==========================================================================
  // pulse counter
  localparam logic [tlim_pkg::CNT_W-1:0] CNT_TOP = tlim_pkg::CNT_FIRST + tlim_pkg::CNT_MORE;
  wire in_pass = (state == tlim_pkg::ST_PASS);
  wire cnt_sat = (pulse_cnt == CNT_TOP);
  wire [tlim_pkg::CNT_W-1:0] cnt_inc = cnt_sat ? pulse_cnt : pulse_cnt + tlim_pkg::CNT_ONE; // R19

  always_comb
  begin
    next_cnt = pulse_cnt;
    if (max_expire)
      next_cnt = tlim_pkg::CNT_ZERO; // R05
    else if (too_close && !in_pass)
      next_cnt = tlim_pkg::CNT_ZERO; // R04
    else if (too_close)
      next_cnt = pulse_cnt; // R06
    else if (link_pulse)
      next_cnt = cnt_inc;
  end

  // ==========================================================================
  // link state
  wire soft_reset = ctrl[tlim_pkg::CTRL_PCS_RST_BIT];
  wire link_ctl = ctrl[tlim_pkg::CTRL_LINK_EN_BIT];

  always_comb
  begin
    next_state = state;
    case (state)
      tlim_pkg::ST_FAIL:
        if (pulse_cnt >= tlim_pkg::CNT_FIRST)
          next_state = tlim_pkg::ST_MORE; // R16
      tlim_pkg::ST_MORE:
        if (pma_carrier)
          next_state = tlim_pkg::ST_CARRIER_END; // R16
        else if (cnt_sat)
          next_state = tlim_pkg::ST_WAIT_CTRL; // R16
      tlim_pkg::ST_CARRIER_END:
        if (!pma_carrier)
          next_state = tlim_pkg::ST_WAIT_CTRL; // R16
      tlim_pkg::ST_WAIT_CTRL:
        if (link_ctl)
          next_state = tlim_pkg::ST_PASS; // R16
      tlim_pkg::ST_PASS:
        if (!link_ctl)
          next_state = tlim_pkg::ST_FAIL;
      default:
        next_state = tlim_pkg::ST_FAIL;
    endcase
    // sourceless transitions win over anything above
    if (max_expire || soft_reset)
      next_state = tlim_pkg::ST_FAIL; // R11 R18
  end

  wire next_pass = (next_state == tlim_pkg::ST_PASS);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= tlim_pkg::ST_FAIL;
      pulse_cnt <= tlim_pkg::CNT_ZERO;
      carrier_q <= 1'b0;
      carrier_seen <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      pulse_cnt <= next_cnt;
      carrier_q <= pma_carrier;
      carrier_seen <= pma_carrier; // R08
    end
  end

  // ==========================================================================
  // data path gating; enables follow next_state so gated outputs line up
  wire send = next_pass && tx_valid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rcv_en <= 1'b0;
      xmit_en <= 1'b0;
      link_status <= 1'b0;
      rx_main_q <= '0;
      rx_a_q <= '0;
      rx_b_q <= '0;
      rx_valid <= 1'b0;
      rx_sym <= '0;
      carrier_status <= 1'b0;
      transmit_pair <= '0;
      bidir_pair_a_out <= '0;
      bidir_pair_b_out <= '0;
      bidir_pair_a_oe <= 1'b0;
      bidir_pair_b_oe <= 1'b0;
      idle_link_signal <= 1'b1;
    end
    else if (ce)
    begin
      rcv_en <= next_pass; // R17
      xmit_en <= next_pass; // R17
      link_status <= next_pass; // R18
      rx_main_q <= receive_pair; // R12
      rx_a_q <= bidir_pair_a_in; // R12
      rx_b_q <= bidir_pair_b_in; // R12
      rx_valid <= next_pass && pma_carrier; // R07
      carrier_status <= next_pass && pma_carrier; // R07 R08
      if (next_pass)
      begin
        rx_sym.main <= tlim_pkg::tlim_decode(rx_main_q); // R14
        rx_sym.pair_a <= tlim_pkg::tlim_decode(rx_a_q); // R14
        rx_sym.pair_b <= tlim_pkg::tlim_decode(rx_b_q); // R14
      end
      else
        rx_sym <= '0; // R07
      // idle requests send nothing; the idle link signal lives on transmit_pair only
      idle_link_signal <= !send; // R09 R15
      bidir_pair_a_oe <= send;
      bidir_pair_b_oe <= send;
      if (send)
      begin
        transmit_pair <= tlim_pkg::tlim_encode(tx_sym.main); // R13
        bidir_pair_a_out <= tlim_pkg::tlim_encode(tx_sym.pair_a); // R13
        bidir_pair_b_out <= tlim_pkg::tlim_encode(tx_sym.pair_b); // R13
      end
      else
      begin
        transmit_pair <= '0; // R09
        bidir_pair_a_out <= '0;
        bidir_pair_b_out <= '0;
      end
    end
  end

  // ==========================================================================
  // sublayer reset: on while bus reset or the control bit is set
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pcs_reset <= 1'b1; // R10
    else if (ce)
      pcs_reset <= soft_reset; // R10
  end

  // ==========================================================================
  // interrupts
  wire tlim_pkg::tlim_irq_t irq_event = '{
    link_up: next_pass && !in_pass,
    link_down: !next_pass && in_pass,
    too_close: too_close
  };
  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ctrl = do_write && w_lane0 && (aw_addr == tlim_pkg::CTRL_OFS);
  wire wr_stat = do_write && w_lane0 && (aw_addr == tlim_pkg::IRQ_STAT_OFS);
  wire wr_mask = do_write && w_lane0 && (aw_addr == tlim_pkg::IRQ_MASK_OFS);
  wire wr_hit = (aw_addr == tlim_pkg::CTRL_OFS) || (aw_addr == tlim_pkg::STATUS_OFS)
      || (aw_addr == tlim_pkg::IRQ_STAT_OFS) || (aw_addr == tlim_pkg::IRQ_MASK_OFS);
  wire [tlim_pkg::IRQ_W-1:0] w1c = wr_stat ? w_data[tlim_pkg::IRQ_W-1:0] : tlim_pkg::IRQ_RESET;
  // a new event beats a clear landing in the same cycle
  wire [tlim_pkg::IRQ_W-1:0] next_irq_stat = (irq_stat & ~w1c) | irq_event;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat <= tlim_pkg::IRQ_RESET;
      irq_mask <= tlim_pkg::IRQ_RESET;
      ctrl <= tlim_pkg::CTRL_RESET;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      irq_stat <= next_irq_stat;
      if (wr_mask)
        irq_mask <= w_data[tlim_pkg::IRQ_W-1:0];
      if (wr_ctrl)
        ctrl <= w_data[1:0];
      irq <= |(next_irq_stat & irq_mask);
    end
  end

  // ==========================================================================
  // AXI4-Lite write: address and data taken in either order, answered after both
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tlim_pkg::RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awready && s_axi_awvalid)
      begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? tlim_pkg::RESP_OKAY : tlim_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read
  wire [31:0] status_word = {17'h00000, pulse_cnt, 3'h0, carrier_seen, state, link_status};
  wire rd_ctrl = (s_axi_araddr == tlim_pkg::CTRL_OFS);
  wire rd_status = (s_axi_araddr == tlim_pkg::STATUS_OFS);
  wire rd_stat = (s_axi_araddr == tlim_pkg::IRQ_STAT_OFS);
  wire rd_mask = (s_axi_araddr == tlim_pkg::IRQ_MASK_OFS);
  wire rd_hit = rd_ctrl || rd_status || rd_stat || rd_mask;
  wire [31:0] rd_word = rd_ctrl ? {30'h00000000, ctrl}
      : rd_status ? status_word
      : rd_stat ? {29'h00000000, irq_stat}
      : rd_mask ? {29'h00000000, irq_mask}
      : 32'h00000000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tlim_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? tlim_pkg::RESP_OKAY : tlim_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // checks
  chk_enables_off_fail: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    ce && next_state != tlim_pkg::ST_PASS |=> !rcv_en && !xmit_en && !link_status)
    else $error("enable high outside link pass");

  chk_rx_idle_off: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    !rcv_en |-> !rx_valid && !carrier_status && rx_sym == '0)
    else $error("receive data while disabled");

  chk_carrier_pass: assert property (@(posedge aclk) disable iff (!aresetn) // R08
    ce && next_pass |=> carrier_status == $past(pma_carrier))
    else $error("carrier not passed while enabled");

  chk_tx_idle_off: assert property (@(posedge aclk) disable iff (!aresetn) // R09
    !xmit_en |-> idle_link_signal && transmit_pair == '0 && !bidir_pair_a_oe)
    else $error("transmit while disabled");

  chk_expire_clears: assert property (@(posedge aclk) disable iff (!aresetn) // R05
    ce && max_expire |=> pulse_cnt == tlim_pkg::CNT_ZERO && state == tlim_pkg::ST_FAIL)
    else $error("expiry did not clear counter");

  chk_close_clears: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    ce && too_close && !in_pass |=> pulse_cnt == tlim_pkg::CNT_ZERO)
    else $error("close pulse did not clear counter");

  chk_pass_ignores: assert property (@(posedge aclk) disable iff (!aresetn) // R06
    ce && too_close && in_pass && !max_expire |=> $stable(pulse_cnt))
    else $error("close pulse changed counter in link pass");

  chk_pass_entry: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    ce && next_pass && !in_pass |-> state == tlim_pkg::ST_WAIT_CTRL && link_ctl)
    else $error("link pass entered early");

  chk_cnt_saturates: assert property (@(posedge aclk) disable iff (!aresetn) // R19
    ce && cnt_sat && link_pulse && !too_close && !max_expire |=> pulse_cnt == CNT_TOP)
    else $error("pulse counter wrapped");

  chk_carrier_restart: assert property (@(posedge aclk) disable iff (!aresetn) // R03
    ce && carrier_rise |=> !max_done)
    else $error("carrier rise did not restart timer");

endmodule : tlim_monitor

// >>> bench/tlim_partner.sv
// far-side link partner: link test pulse bursts and the levels on our receive pair
// assumes one aclk; go is a one-cycle strobe from the bench
module tlim_partner (
  input wire logic aclk, // clock
  input wire logic go, // start a burst
  input wire logic [7:0] n, // pulses in the burst
  input wire logic [7:0] gap, // idle cycles between pulses
  input wire logic carrier, // frame under way
  input wire tlim_pkg::tlim_lvl_t lvl, // level sent within a frame
  output logic link_pulse, // one strobe per link test pulse
  output logic busy, // burst under way
  output tlim_pkg::tlim_lvl_t pair // levels on the receive pair
);
  timeunit 1ns;
  timeprecision 1ps;
  int left = 0;
  int cnt = 0;
  logic tog = 1'b0;
  initial link_pulse = 1'b0;
  assign busy = (left != 0);
  // no frame: the pair toggles so that stale data never looks valid
  assign pair = carrier ? lvl : {tog, !tog};
  always @(posedge aclk)
  begin
    tog <= !tog;
    link_pulse <= 1'b0;
    if (go)
    begin
      left <= int'(n);
      cnt <= 0;
    end
    else if (left != 0 && cnt == 0)
    begin
      link_pulse <= 1'b1;
      left <= left - 1;
      cnt <= int'(gap);
    end
    else if (left != 0)
      cnt <= cnt - 1;
  end
endmodule : tlim_partner

// >>> bench/tb_ternary_link_integrity_monitor.sv
// self-checking bench of the link integrity monitor and its far-side partner
// assumes the package and monitor under logic/; one 100 MHz clock
module tb_ternary_link_integrity_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, pma_carrier = 1'b0, tx_valid = 1'b0;
  logic go = 1'b0, link_pulse, busy, idle_link_signal, carrier_status;
  logic rcv_en, xmit_en, link_status, pcs_reset, irq, rx_valid;
  logic [7:0] n = 8'h00, gap = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  tlim_pkg::tlim_sym3_t tx_sym = 6'h00, rx_sym;
  tlim_pkg::tlim_lvl_t lvl = 2'h0, receive_pair, transmit_pair;
  tlim_pkg::tlim_sym_t syms [3] = '{tlim_pkg::SYM_PLUS, tlim_pkg::SYM_ZERO, tlim_pkg::SYM_MINUS};
  tlim_pkg::tlim_lvl_t lvls [3] = '{2'h2, 2'h0, 2'h1};
  logic [33:0] exp_q [$];
  int failures = 0, checks = 0, cycles = 0, k;

  tlim_monitor #(.LINK_MAX_CYCLES(200), .LINK_MIN_CYCLES(20)) i_dut (
    .aclk, .aresetn, .ce, .link_pulse, .pma_carrier, .receive_pair,
    .bidir_pair_a_in(receive_pair), .bidir_pair_b_in(receive_pair), .tx_valid, .tx_sym,
    .transmit_pair, .bidir_pair_a_out(), .bidir_pair_a_oe(), .bidir_pair_b_out(),
    .bidir_pair_b_oe(), .idle_link_signal, .rx_valid, .rx_sym, .carrier_status, .rcv_en,
    .xmit_en, .link_status, .pcs_reset, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tlim_partner i_partner (.aclk, .go, .n, .gap, .carrier(pma_carrier), .lvl, .link_pulse,
    .busy, .pair(receive_pair));

  initial forever #5 aclk = ~aclk;

  // ==========================================================================
  // checking and bus tasks
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = tlim_pkg::RESP_OKAY);
    exp_q.push_back({r, 32'h00000000});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r = tlim_pkg::RESP_OKAY);
    exp_q.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic pulses(input logic [7:0] cnt, input logic [7:0] g);
    @(posedge aclk);
    n <= cnt;
    gap <= g;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask : pulses

  // bus answers are compared against the oldest note as they arrive
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", {s_axi_bresp, 32'h00000000}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end

  // about 6000 cycles are needed; the ceiling leaves ample margin
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      wrap_up();
    end
  end

  // ==========================================================================
  // tests
  initial
  begin
    void'($urandom(68));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(tlim_pkg::CTRL_OFS, 32'h00000000);
    rd(tlim_pkg::STATUS_OFS, 32'h00000000);
    rd(8'h10, 32'h00000000, tlim_pkg::RESP_SLVERR);
    wr(8'h10, 32'h00000001, tlim_pkg::RESP_SLVERR);
    wr(tlim_pkg::IRQ_MASK_OFS, 32'h00000007);
    $display("test reset done");
    pulses(8'h1F, 8'h1E);
    rd(tlim_pkg::STATUS_OFS, 32'h00001F02);
    pulses(8'h02, 8'h05);
    rd(tlim_pkg::STATUS_OFS, 32'h00000002);
    chk("rcv_en", rcv_en, 34'h0);
    chk("xmit_en", xmit_en, 34'h0);
    wr(tlim_pkg::CTRL_OFS, 32'h00000001);
    pulses(8'h82, 8'h1E);
    rd(tlim_pkg::STATUS_OFS, 32'h00007F09);
    chk("link_status", link_status, 34'h1);
    pulses(8'h02, 8'h05);
    rd(tlim_pkg::STATUS_OFS, 32'h00007F09);
    $display("test link pass done");
    for (int i = 0; i < 6; i++)
    begin
      k = $urandom % 3;
      @(posedge aclk);
      tx_valid <= 1'b1;
      tx_sym <= {syms[k], tlim_pkg::SYM_ZERO, tlim_pkg::SYM_ZERO};
      pma_carrier <= 1'b1;
      lvl <= lvls[k];
      repeat (4) @(posedge aclk);
      chk("transmit_pair", transmit_pair, lvls[k]);
      chk("rx_sym", rx_sym.main, syms[k]);
      chk("carrier_status", carrier_status, 34'h1);
      chk("rx_valid", rx_valid, 34'h1);
    end
    chk("idle_link_signal", idle_link_signal, 34'h0);
    rd(tlim_pkg::IRQ_STAT_OFS, 32'h00000005);
    chk("irq", irq, 34'h1);
    wr(tlim_pkg::IRQ_STAT_OFS, 32'h00000005);
    wr(tlim_pkg::IRQ_MASK_OFS, 32'h00000000);
    rd(tlim_pkg::IRQ_STAT_OFS, 32'h00000000);
    $display("test data path done");
    pma_carrier <= 1'b0;
    ce <= 1'b0;
    repeat (260) @(posedge aclk);
    chk("link_status", link_status, 34'h1);
    ce <= 1'b1;
    repeat (260) @(posedge aclk);
    chk("link_status", link_status, 34'h0);
    chk("rcv_en", rcv_en, 34'h0);
    rd(tlim_pkg::STATUS_OFS, 32'h00000000);
    rd(tlim_pkg::IRQ_STAT_OFS, 32'h00000002);
    chk("irq", irq, 34'h0);
    wr(tlim_pkg::IRQ_MASK_OFS, 32'h00000002);
    pma_carrier <= 1'b1;
    repeat (4) @(posedge aclk);
    chk("irq", irq, 34'h1);
    chk("carrier_status", carrier_status, 34'h0);
    chk("rx_sym", rx_sym, 34'h0);
    chk("transmit_pair", transmit_pair, 34'h0);
    chk("idle_link_signal", idle_link_signal, 34'h1);
    rd(tlim_pkg::STATUS_OFS, 32'h00000010);
    wr(tlim_pkg::CTRL_OFS, 32'h00000002);
    repeat (2) @(posedge aclk);
    chk("pcs_reset", pcs_reset, 34'h1);
    rd(tlim_pkg::CTRL_OFS, 32'h00000002);
    $display("test link loss done");
    repeat (2) @(posedge aclk);
    wrap_up();
  end
endmodule : tb_ternary_link_integrity_monitor
